// [src/bus_cycle_cfg.svh]
// Timing counts and Avalon-MM register map for the bus-cycle controller.
`ifndef BUS_CYCLE_CFG_SVH
`define BUS_CYCLE_CFG_SVH

`define WAITS_SLOW 4'h4
`define WAITS_IO16 4'h1
`define WAITS_MEM16 4'h1
`define WAITS_ROM_LONG 4'h3
`define WAITS_ROM_SHORT 4'h2
`define WAITS_RAM_FAST 4'h0
`define WAITS_RAM_SLOW 4'h1
`define TEST_COMBO_NS 60
`define CLOCK_NS 50
`define TEST_COMBO_CYCLES (((`TEST_COMBO_NS) / (`CLOCK_NS)) < 1 ? 1 : ((`TEST_COMBO_NS) / (`CLOCK_NS)))
`define REG_CONTROL 4'h0
`define REG_STATUS 4'h4
`define REG_COUNT 4'h8
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 8'h01

`endif

// [src/bus_cycle_pkg.sv]
// Types shared by the bus-cycle controller files.
package bus_cycle_pkg;
    typedef enum logic [2:0] {
        CYC_IDLE = 3'b000,
        CYC_CMD_DELAY = 3'b001,
        CYC_WAIT = 3'b011,
        CYC_LOW_DONE = 3'b010,
        CYC_HIGH = 3'b110,
        CYC_END = 3'b111
    } cycle_state_t;
    typedef enum logic [2:0] {
        ACC_INTERRUPT_ACKNOWLEDGE_CYCLE = 3'h0,
        ACC_IO = 3'h1,
        ACC_MEM_READ = 3'h2,
        ACC_MEM_WRITE = 3'h3,
        ACC_ROM_READ = 3'h4
    } access_t;
endpackage

// [src/pin_sync.sv]
// Two-flop synchroniser for a bundle of pin inputs.
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Raw and synchronised levels.
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] meta_r;

    // Only the second stage may read the first.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_r <= RESET_VALUE;
            pinOut <= RESET_VALUE;
        end else begin
            meta_r <= pinIn;
            pinOut <= meta_r;
        end
    end
endmodule // pin_sync

// [src/bus_cycle_ctrl.sv]
// Bus-cycle wait, refresh and 16-to-8 conversion controller with an Avalon-MM register port.
`timescale 1ns/100ps
`include "bus_cycle_cfg.svh"

// Behaviour
// - Interrupt acknowledge and 8-bit I/O get 4 waits; 16-bit I/O 1; all delayed.
// - Off-board memory: 4 waits delayed if 8-bit, 1 wait undelayed if 16-bit.
// - On-board ROM 3 or 2 waits by extra-wait input; DRAM 0 or 1; undelayed.
// - Channel ready low holds the cycle open until it returns high or zero-wait goes low.
// - Zero-wait request low ends the cycle at once; in a conversion it ends each half, with the low-done step between.
// - Refresh request low asserts the refresh address enable output.
// - Refresh request under hold acknowledge also drives the memory read command.
// - Conversion machine drives byte-swap direction, gate and command suppress.
// - Conversion holds the processor and moves the low byte first.
// - Then latch low byte on reads, drop commands, raise address bit zero, move high.
// - Eight-bit DMA routes system low byte to high or low memory byte.
// - Read-wait select sampled on reads, write-wait on writes; high adds a wait.
module bus_cycle_ctrl (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Avalon-MM register port.
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    // Processor cycle request, from logic on this clock.
    input wire logic cycleStart,
    input wire bus_cycle_pkg::access_t cycleType,
    input wire logic cycleWord,
    input wire logic [7:0] busDataLow,
    // Board pins.
    input wire logic onboard_select,
    input wire logic memCs16n,
    input wire logic ioCs16n,
    input wire logic rom_extra_wait,
    input wire logic dram_read_wait_select,
    input wire logic dram_write_wait_select,
    input wire logic channelReady,
    input wire logic zeroWaitn,
    input wire logic refreshn,
    input wire logic processor_hold_ack,
    input wire logic dmaByteCycle,
    input wire logic dmaHighByte,
    input wire logic dmaToMemory,
    // Outputs.
    output logic processorReadyn,
    output logic commandActive,
    output logic memReadCmdn,
    output logic refreshAddressEnablen,
    output logic sysAddr0,
    output logic byte_swap_direction,
    output logic byte_swap_gate,
    output logic command_suppress,
    output logic [7:0] lowByteLatch
);
    localparam int COMBO_LIMIT = `TEST_COMBO_CYCLES;
    localparam logic [7:0] CTRL_INIT = `CTRL_RESET;

    // Pins other than dmaHighByte and dmaToMemory synchronised before use.
    logic [10:0] pinsSync;
    logic sOnboard, sMem16n, sIo16n, sRomWait, sRdWait, sWrWait, sReady, sZeroWaitn, sRefreshn, sHold, sDma;
    // Reset value is the idle level of every pin, so no false hold, stall or test combination follows reset.
    pin_sync #(.WIDTH(11), .RESET_VALUE(11'h31c)) pinSyncInst (
        .clock(clock),
        .rstn(rstn),
        .pinIn({onboard_select, memCs16n, ioCs16n, rom_extra_wait, dram_read_wait_select,
            dram_write_wait_select, channelReady, zeroWaitn, refreshn, processor_hold_ack, dmaByteCycle}),
        .pinOut(pinsSync)
    );
    assign {sOnboard, sMem16n, sIo16n, sRomWait, sRdWait, sWrWait, sReady, sZeroWaitn, sRefreshn, sHold, sDma} = pinsSync;

    // Wait count and command delay for an access.
    function automatic logic [4:0] waitPlan(input bus_cycle_pkg::access_t t, input logic onb, input logic m16n,
                                            input logic io16n, input logic romw, input logic rdw, input logic wrw);
        logic [4:0] r;
        r = {`WAITS_SLOW, 1'b1};
        unique case (t)
            bus_cycle_pkg::ACC_INTERRUPT_ACKNOWLEDGE_CYCLE: r = {`WAITS_SLOW, 1'b1};
            bus_cycle_pkg::ACC_IO: r = io16n ? {`WAITS_SLOW, 1'b1} : {`WAITS_IO16, 1'b1};
            default: begin
                if (!onb) begin
                    r = m16n ? {`WAITS_SLOW, 1'b1} : {`WAITS_MEM16, 1'b0};
                end else if (t == bus_cycle_pkg::ACC_ROM_READ) begin
                    r = romw ? {`WAITS_ROM_LONG, 1'b0} : {`WAITS_ROM_SHORT, 1'b0};
                end else if (t == bus_cycle_pkg::ACC_MEM_WRITE) begin
                    r = wrw ? {`WAITS_RAM_SLOW, 1'b0} : {`WAITS_RAM_FAST, 1'b0};
                end else begin
                    r = rdw ? {`WAITS_RAM_SLOW, 1'b0} : {`WAITS_RAM_FAST, 1'b0};
                end
            end
        endcase
        return r;
    endfunction

    bus_cycle_pkg::cycle_state_t state_r, state_nxt;
    logic [3:0] waits_r, waits_nxt;
    logic isRead_r, convert_r, enable_r;
    logic [7:0] lowByte_r;
    logic [15:0] cycleCount_r;
    logic [4:0] plan;
    logic waitsDone, cycleEnds, convNeeded, accepting;

    assign plan = waitPlan(cycleType, sOnboard, sMem16n, sIo16n, sRomWait, sRdWait, sWrWait);
    assign waitsDone = (waits_r == 4'h0);
    // Zero-wait cuts short; otherwise channel ready gates the programmed count.
    assign cycleEnds = !sZeroWaitn || (waitsDone && sReady);
    assign convNeeded = cycleWord && (cycleType == bus_cycle_pkg::ACC_IO || (!sOnboard && sMem16n));
    assign accepting = enable_r && cycleStart && !sHold;

    always_comb begin
        state_nxt = state_r;
        waits_nxt = (waits_r != 4'h0) ? waits_r - 4'h1 : waits_r;
        unique case (state_r)
            bus_cycle_pkg::CYC_IDLE: begin
                if (accepting) begin
                    waits_nxt = plan[4:1];
                    state_nxt = plan[0] ? bus_cycle_pkg::CYC_CMD_DELAY : bus_cycle_pkg::CYC_WAIT;
                end
            end
            bus_cycle_pkg::CYC_CMD_DELAY: begin
                waits_nxt = waits_r;
                state_nxt = bus_cycle_pkg::CYC_WAIT;
            end
            bus_cycle_pkg::CYC_WAIT: begin
                if (cycleEnds) begin
                    state_nxt = convert_r ? bus_cycle_pkg::CYC_LOW_DONE : bus_cycle_pkg::CYC_END;
                end
            end
            bus_cycle_pkg::CYC_LOW_DONE: begin
                waits_nxt = `WAITS_SLOW;
                state_nxt = bus_cycle_pkg::CYC_HIGH;
            end
            bus_cycle_pkg::CYC_HIGH: begin
                if (cycleEnds) begin
                    state_nxt = bus_cycle_pkg::CYC_END;
                end
            end
            bus_cycle_pkg::CYC_END: state_nxt = bus_cycle_pkg::CYC_IDLE;
            default: state_nxt = bus_cycle_pkg::CYC_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= bus_cycle_pkg::CYC_IDLE;
            waits_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            waits_r <= waits_nxt;
        end
    end

    // Access attributes are held for the whole cycle.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            isRead_r <= 1'b0;
            convert_r <= 1'b0;
        end else if (state_r == bus_cycle_pkg::CYC_IDLE && accepting) begin
            isRead_r <= (cycleType != bus_cycle_pkg::ACC_MEM_WRITE);
            convert_r <= convNeeded;
        end
    end

    // Low byte captured as the first half of a converted read closes.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lowByte_r <= 8'h00;
        end else if (state_r == bus_cycle_pkg::CYC_LOW_DONE && isRead_r) begin
            lowByte_r <= busDataLow;
        end
    end
    assign lowByteLatch = lowByte_r;

    // Ready is held off through both halves of a conversion.
    assign processorReadyn = (state_r != bus_cycle_pkg::CYC_END);
    assign commandActive = (state_r == bus_cycle_pkg::CYC_WAIT || state_r == bus_cycle_pkg::CYC_HIGH);
    assign command_suppress = (state_r == bus_cycle_pkg::CYC_LOW_DONE);
    assign sysAddr0 = (state_r == bus_cycle_pkg::CYC_LOW_DONE || state_r == bus_cycle_pkg::CYC_HIGH);
    // Swap gate opens with address bit zero, from the low-done step through the high half of a conversion, or for an 8-bit DMA to the high byte.
    assign byte_swap_gate = sysAddr0 || (sHold && sDma && dmaHighByte);
    assign byte_swap_direction = (sHold && sDma) ? dmaToMemory : !isRead_r;
    // Refresh drives the memory read command only under hold acknowledge; the address enable follows refresh alone.
    assign refreshAddressEnablen = sRefreshn;
    assign memReadCmdn = !((!sRefreshn && sHold) || (commandActive && isRead_r && !convert_r)
                           || (commandActive && isRead_r && convert_r));

    // Watches the forbidden wait-select test combination.
    logic [3:0] comboCount_r;
    logic comboSeen_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            comboCount_r <= 4'h0;
            comboSeen_r <= 1'b0;
        end else begin
            comboCount_r <= (sRdWait && !sWrWait) ? ((comboCount_r == 4'hf) ? comboCount_r : comboCount_r + 4'h1) : 4'h0;
            if (comboCount_r > 4'(COMBO_LIMIT)) begin
                comboSeen_r <= 1'b1;
            end
        end
    end

    // Register port: control enable, status, completed cycle count.
    logic regHit, endPulse, rdDone_r;
    assign endPulse = (state_r == bus_cycle_pkg::CYC_END);
    // A read is held one cycle so that its registered data already stand when waitrequest falls.
    assign avsWaitrequest = avsRead && !rdDone_r;
    assign regHit = (avsAddress == `REG_CONTROL);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            enable_r <= CTRL_INIT[`CTRL_ENABLE_BIT];
            cycleCount_r <= 16'h0000;
        end else begin
            if (avsWrite && regHit) begin
                enable_r <= avsWritedata[`CTRL_ENABLE_BIT];
            end
            if (endPulse) begin
                cycleCount_r <= cycleCount_r + 16'h0001;
            end
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            avsReaddata <= 32'h00000000;
            rdDone_r <= 1'b0;
        end else begin
            rdDone_r <= avsRead && !rdDone_r;
            if (avsRead && !rdDone_r) begin
                unique case (avsAddress)
                    `REG_CONTROL: avsReaddata <= {31'h0, enable_r};
                    `REG_STATUS: avsReaddata <= {24'h0, comboSeen_r, convert_r, sHold, 2'h0, state_r};
                    `REG_COUNT: avsReaddata <= {16'h0, cycleCount_r};
                    default: avsReaddata <= 32'h00000000;
                endcase
            end
        end
    end

    // Assertions.
    sequence s_startDelayed;
        state_r == bus_cycle_pkg::CYC_IDLE && accepting && plan[0];
    endsequence
    property p_delayFirst;
        @(posedge clock) disable iff (!rstn) s_startDelayed |=> state_r == bus_cycle_pkg::CYC_CMD_DELAY;
    endproperty
    a_delayFirst: assert property (p_delayFirst) else $error("command delay skipped");
    property p_io8;
        @(posedge clock) disable iff (!rstn)
            (state_r == bus_cycle_pkg::CYC_IDLE && accepting && cycleType == bus_cycle_pkg::ACC_IO && sIo16n)
            |=> waits_r == 4'h4;
    endproperty
    a_io8: assert property (p_io8) else $error("8-bit I/O wait count wrong");
    property p_mem16;
        @(posedge clock) disable iff (!rstn)
            (state_r == bus_cycle_pkg::CYC_IDLE && accepting && !sOnboard && !sMem16n
             && (cycleType == bus_cycle_pkg::ACC_MEM_READ || cycleType == bus_cycle_pkg::ACC_MEM_WRITE))
            |=> state_r == bus_cycle_pkg::CYC_WAIT && waits_r == 4'h1;
    endproperty
    a_mem16: assert property (p_mem16) else $error("16-bit off-board memory plan wrong");
    property p_rom;
        @(posedge clock) disable iff (!rstn)
            (state_r == bus_cycle_pkg::CYC_IDLE && accepting && cycleType == bus_cycle_pkg::ACC_ROM_READ
             && sOnboard) |=> waits_r == (($past(sRomWait)) ? 4'h3 : 4'h2);
    endproperty
    a_rom: assert property (p_rom) else $error("ROM wait count wrong");
    property p_holdReady;
        @(posedge clock) disable iff (!rstn)
            (state_r == bus_cycle_pkg::CYC_WAIT && !sReady && sZeroWaitn) |=> state_r != bus_cycle_pkg::CYC_END;
    endproperty
    a_holdReady: assert property (p_holdReady) else $error("cycle ended while channel not ready");
    property p_zeroWait;
        @(posedge clock) disable iff (!rstn)
            (state_r == bus_cycle_pkg::CYC_WAIT && !sZeroWaitn && !convert_r) |=> ##[0:1] !processorReadyn;
    endproperty
    a_zeroWait: assert property (p_zeroWait) else $error("zero-wait request not honoured");
    property p_refresh;
        @(posedge clock) disable iff (!rstn) (!sRefreshn && sHold) |-> !refreshAddressEnablen && !memReadCmdn;
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh outputs missing");
    sequence s_lowHalf;
        state_r == bus_cycle_pkg::CYC_WAIT && convert_r && cycleEnds;
    endsequence
    property p_convert;
        @(posedge clock) disable iff (!rstn)
            s_lowHalf |=> command_suppress && sysAddr0 ##1 !command_suppress && sysAddr0 && processorReadyn;
    endproperty
    a_convert: assert property (p_convert) else $error("conversion sequence wrong");
endmodule // bus_cycle_ctrl

// [testbench/bus_agent_model.sv]
// Model of the processor hold logic and expansion bus agents that drive the controller's bus pins.
`timescale 1ns/100ps
module bus_agent_model (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Scenario controls from the bench.
    input wire logic holdGo,
    input wire logic refreshGo,
    input wire logic cutGo,
    input wire logic [4:0] stretchLen,
    // Controller side.
    input wire logic commandActive,
    // Pins towards the controller.
    output logic channelReady,
    output logic zeroWaitn,
    output logic refreshn,
    output logic processor_hold_ack
);
    logic [4:0] activeCnt_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            activeCnt_r <= 5'h00;
            processor_hold_ack <= 1'h0;
            refreshn <= 1'h1;
        end else begin
            processor_hold_ack <= holdGo;
            refreshn <= !(refreshGo && processor_hold_ack);
            if (!commandActive)
                activeCnt_r <= 5'h00;
            else if (activeCnt_r != 5'h1f)
                activeCnt_r <= activeCnt_r + 5'h01;
        end
    end
    // Ready stays low until the command has run for the asked stretch, so a slow agent really stalls.
    assign channelReady = (activeCnt_r >= stretchLen);
    // The cut-short request is withheld while ready is low, so both are never low together.
    assign zeroWaitn = !(cutGo && channelReady);
endmodule // bus_agent_model

// [testbench/bus_cycle_ctrl_bench.sv]
// Self-checking bench for the bus-cycle controller.
`timescale 1ns/100ps
module bus_cycle_ctrl_bench;
    logic clock = 1'h0, rstn = 1'h0, avsRead = 1'h0, avsWrite = 1'h0, avsWaitrequest, cycleStart = 1'h0;
    logic [3:0] avsAddress = 4'h0, g, d;
    logic [31:0] avsWritedata = 32'h0, avsReaddata, q;
    bus_cycle_pkg::access_t cycleType = bus_cycle_pkg::ACC_INTERRUPT_ACKNOWLEDGE_CYCLE;
    logic cycleWord = 1'h0, onboard_select = 1'h0, memCs16n = 1'h1, ioCs16n = 1'h1, rom_extra_wait = 1'h0;
    logic dram_read_wait_select = 1'h0, dram_write_wait_select = 1'h0;
    logic dmaByteCycle = 1'h0, dmaHighByte = 1'h0, dmaToMemory = 1'h0, holdGo = 1'h0, refreshGo = 1'h0, cutGo = 1'h0;
    logic [4:0] stretchLen = 5'h00;
    logic [7:0] busDataLow = 8'h5a, lowByteLatch;
    logic channelReady, zeroWaitn, refreshn, processor_hold_ack, processorReadyn, commandActive, memReadCmdn;
    logic refreshAddressEnablen, sysAddr0, byte_swap_direction, byte_swap_gate, command_suppress;
    logic sup, lowSeen, highSeen, gateSeen;
    int fails = 0, cmp_count = 0, cyclesRun = 0, n;
    always #25 clock = ~clock;
    bus_cycle_ctrl dut_u (.clock(clock), .rstn(rstn), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .cycleStart(cycleStart), .cycleType(cycleType), .cycleWord(cycleWord),
        .busDataLow(busDataLow), .onboard_select(onboard_select), .memCs16n(memCs16n), .ioCs16n(ioCs16n),
        .rom_extra_wait(rom_extra_wait), .dram_read_wait_select(dram_read_wait_select),
        .dram_write_wait_select(dram_write_wait_select), .channelReady(channelReady), .zeroWaitn(zeroWaitn),
        .refreshn(refreshn), .processor_hold_ack(processor_hold_ack), .dmaByteCycle(dmaByteCycle),
        .dmaHighByte(dmaHighByte), .dmaToMemory(dmaToMemory), .processorReadyn(processorReadyn),
        .commandActive(commandActive), .memReadCmdn(memReadCmdn), .refreshAddressEnablen(refreshAddressEnablen),
        .sysAddr0(sysAddr0), .byte_swap_direction(byte_swap_direction), .byte_swap_gate(byte_swap_gate),
        .command_suppress(command_suppress), .lowByteLatch(lowByteLatch));
    bus_agent_model agent_u (.clock(clock), .rstn(rstn), .holdGo(holdGo), .refreshGo(refreshGo), .cutGo(cutGo),
        .stretchLen(stretchLen), .commandActive(commandActive), .channelReady(channelReady),
        .zeroWaitn(zeroWaitn), .refreshn(refreshn), .processor_hold_ack(processor_hold_ack));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic bail();
        fails++;
        $display("ERROR at %0t: wait ran out", $time);
        close_out();
    endtask
    task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] dat);
        int i;
        @(posedge clock);
        avsAddress <= a;
        avsWritedata <= dat;
        avsWrite <= wr;
        avsRead <= !wr;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (avsWaitrequest === 1'h0) begin
                q = avsReaddata;
                break;
            end
        end
        if (i == 50) bail();
        avsRead <= 1'h0;
        avsWrite <= 1'h0;
    endtask
    // Pins pass a two-flop synchroniser, so they are settled a few cycles before a cycle starts.
    task automatic set_pins(input logic io16n, onb, mcs, romw, rdw, wrw);
        @(posedge clock);
        ioCs16n <= io16n;
        onboard_select <= onb;
        memCs16n <= mcs;
        rom_extra_wait <= romw;
        dram_read_wait_select <= rdw;
        dram_write_wait_select <= wrw;
        repeat (4) @(posedge clock);
    endtask
    task automatic run_cycle(input bus_cycle_pkg::access_t t, input logic w);
        int i;
        sup = 0; lowSeen = 0; highSeen = 0; gateSeen = 0;
        @(posedge clock);
        cycleType <= t;
        cycleWord <= w;
        cycleStart <= 1'h1;
        @(posedge clock);
        cycleStart <= 1'h0;
        n = 0;
        for (i = 0; i < 80; i++) begin
            @(posedge clock);
            // Sampled at the edge, so n counts the edge that first sees ready low.
            n++;
            if (processorReadyn === 1'h0) break;
            if (commandActive === 1'h1 && sysAddr0 === 1'h0 && !sup) lowSeen = 1;
            if (command_suppress === 1'h1 && !sup) begin
                sup = 1;
                busDataLow <= 8'h3c;
            end
            if (sup && commandActive === 1'h1 && sysAddr0 === 1'h1) highSeen = 1;
            if (byte_swap_gate === 1'h1) gateSeen = 1;
        end
        if (i == 80) bail();
        cyclesRun++;
    endtask
    task automatic row(input bus_cycle_pkg::access_t t, input logic io16n, onb, mcs, romw, rdw, wrw, input int e);
        set_pins(io16n, onb, mcs, romw, rdw, wrw);
        run_cycle(t, 1'h0);
        check(n, e);
    endtask
    task automatic test_regs();
        int i;
        avs(1'h0, 4'h0, 32'h0);
        check(q, 32'h1);
        avs(1'h0, 4'hc, 32'h0);
        check(q, 32'h0);
        avs(1'h1, 4'h0, 32'h0);
        @(posedge clock);
        cycleStart <= 1'h1;
        for (i = 0; i < 20; i++) @(posedge clock) check(processorReadyn, 1'h1);
        cycleStart <= 1'h0;
        avs(1'h1, 4'hc, 32'h0);
        avs(1'h1, 4'h0, 32'h1);
        avs(1'h0, 4'h0, 32'h0);
        check(q, 32'h1);
        $display("register test done");
    endtask
    task automatic test_waits();
        // Three plus waits for delayed commands, two plus waits for undelayed ones.
        row(bus_cycle_pkg::ACC_INTERRUPT_ACKNOWLEDGE_CYCLE, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 7);
        row(bus_cycle_pkg::ACC_IO, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 7);
        row(bus_cycle_pkg::ACC_IO, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 4);
        row(bus_cycle_pkg::ACC_MEM_READ, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 7);
        row(bus_cycle_pkg::ACC_MEM_WRITE, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3);
        row(bus_cycle_pkg::ACC_ROM_READ, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 5);
        row(bus_cycle_pkg::ACC_ROM_READ, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 4);
        row(bus_cycle_pkg::ACC_MEM_READ, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 2);
        row(bus_cycle_pkg::ACC_MEM_READ, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 2);
        row(bus_cycle_pkg::ACC_MEM_WRITE, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 3);
        row(bus_cycle_pkg::ACC_MEM_READ, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 3);
        row(bus_cycle_pkg::ACC_MEM_WRITE, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 2);
        $display("wait table test done");
    endtask
    task automatic test_override();
        stretchLen <= 5'h0c;
        // Ready rises after 12 command cycles, then needs two more to pass the synchroniser.
        row(bus_cycle_pkg::ACC_INTERRUPT_ACKNOWLEDGE_CYCLE, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 17);
        check(n > 12 && n < 24, 1'h1);
        stretchLen <= 5'h00;
        cutGo <= 1'h1;
        row(bus_cycle_pkg::ACC_INTERRUPT_ACKNOWLEDGE_CYCLE, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 3);
        cutGo <= 1'h0;
        $display("override test done");
    endtask
    task automatic test_convert();
        busDataLow <= 8'h5a;
        set_pins(1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
        run_cycle(bus_cycle_pkg::ACC_MEM_READ, 1'h1);
        check({lowSeen, sup, highSeen}, 3'h7);
        check(gateSeen, 1'h1);
        check(lowByteLatch, 8'h5a);
        $display("conversion test done");
    endtask
    task automatic test_hold();
        holdGo <= 1'h1;
        refreshGo <= 1'h1;
        repeat (6) @(posedge clock);
        check({refreshAddressEnablen, memReadCmdn}, 2'h0);
        refreshGo <= 1'h0;
        repeat (6) @(posedge clock);
        check({refreshAddressEnablen, memReadCmdn}, 2'h3);
        dmaByteCycle <= 1'h1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            dmaHighByte <= k[0];
            dmaToMemory <= k[1];
            repeat (5) @(posedge clock);
            g[k] = byte_swap_gate;
            d[k] = byte_swap_direction;
        end
        check({g[0] ^ g[1], g[2] ^ g[3], d[0] ^ d[2], d[1] ^ d[3]}, 4'hf);
        dmaByteCycle <= 1'h0;
        holdGo <= 1'h0;
        repeat (4) @(posedge clock);
        $display("hold test done");
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'h1;
        repeat (3) @(posedge clock);
        test_regs();
        test_waits();
        test_override();
        test_convert();
        test_hold();
        avs(1'h0, 4'h8, 32'h0);
        check(q, 32'(cyclesRun));
        // The bench never set read-wait high with write-wait low, so the test-combination flag stays clear.
        avs(1'h0, 4'h4, 32'h0);
        check(q[7], 1'h0);
        close_out();
    end
endmodule // bus_cycle_ctrl_bench
